//--- inc/eau_pkg.sv
/*
 Shared constants and types for the effective address unit.
 Assumes the decode stage presents a resolved addressing mode and
 class, and that the register file answers reads combinationally.
*/
`default_nettype none
package eau_pkg;
   localparam int ADDR_W = 24;
   localparam int REG_W = 32;
   localparam int WORD_W = 16;
   localparam int NREG = 8;
   localparam int SEL_W = 3;
   localparam int OPF_MSB = 15;
   localparam int OPF_LSB = 12;
   localparam int REGA_LSB = 4;
   localparam int REGB_LSB = 0;
   localparam int DSEL_W = 4;
   localparam int BITNUM_LSB = 4;
   localparam int BITNUM_W = 3;
   localparam int TRAP_LSB = 4;
   localparam int TRAP_W = 2;
   localparam int COND_LSB = 8;
   localparam int COND_W = 4;
   localparam logic [15:0] SHORT_ABS_FILL = 16'hffff;
   localparam logic [15:0] PTR_ZERO_FILL = 16'h0000;
   localparam logic [7:0] EXT_TOP_ZERO = 8'h00;
   localparam logic [REG_W-1:0] STEP_BYTE = 32'h0000_0001;
   localparam logic [REG_W-1:0] STEP_WORD = 32'h0000_0002;
   localparam logic [REG_W-1:0] STEP_LONG = 32'h0000_0004;
   localparam logic [ADDR_W-1:0] TRAP_VEC_BASE = 24'h000020;
   localparam logic [ADDR_W-1:0] TRAP_VEC_STEP = 24'h000004;
   localparam int MEM_STATES = 2;
   typedef enum logic [3:0] {
      EAU_REG_DIRECT, EAU_REG_IND, EAU_REG_DISP16, EAU_REG_DISP24,
      EAU_POST_INC, EAU_PRE_DEC, EAU_ABS8, EAU_ABS16, EAU_ABS24,
      EAU_IMM8, EAU_IMM16, EAU_IMM32, EAU_PC_REL8, EAU_PC_REL16, EAU_PTR_IND
   } eau_mode_e;
   typedef enum logic [1:0] {EAU_SZ_BYTE, EAU_SZ_WORD, EAU_SZ_LONG} eau_size_e;
   typedef enum logic [1:0] {EAU_CL_ALU, EAU_CL_MOVE, EAU_CL_BIT, EAU_CL_BRANCH} eau_class_e;
endpackage
`default_nettype wire

//--- inc/eau_fld_if.sv
/*
 Decoded instruction fields passed from the field splitter to the core.
 Assumes a single clock domain; carries only combinational values.
*/
`default_nettype none
interface eau_fld_if;
   import eau_pkg::*;
   logic [3:0] operation_field;
   logic [SEL_W-1:0] sel_a;
   logic [SEL_W-1:0] sel_b;
   logic [DSEL_W-1:0] dsel_b;
   logic [BITNUM_W-1:0] bit_imm;
   logic [TRAP_W-1:0] trap_imm;
   logic [COND_W-1:0] branch_condition_field;
   modport src (output operation_field, sel_a, sel_b, dsel_b, bit_imm, trap_imm, branch_condition_field);
   modport dst (input operation_field, sel_a, sel_b, dsel_b, bit_imm, trap_imm, branch_condition_field);
endinterface
`default_nettype wire

//--- rtl/eau_fields.sv
/*
 Splits the first instruction word into its fields.
 Assumes the word is already held stable by the decode stage.
*/
`default_nettype none
module eau_fields
   import eau_pkg::*;
(
   input wire logic [eau_pkg::WORD_W-1:0] first_word, // First instruction word
   eau_fld_if.src fld                                 // Decoded fields
);
   // Fixed slices; widths come from the package
   assign fld.operation_field = first_word[OPF_MSB:OPF_LSB]; // RULE_02
   assign fld.sel_a = first_word[REGA_LSB +: SEL_W]; // RULE_03
   assign fld.sel_b = first_word[REGB_LSB +: SEL_W];
   assign fld.dsel_b = first_word[REGB_LSB +: DSEL_W];
   assign fld.bit_imm = first_word[BITNUM_LSB +: BITNUM_W]; // RULE_14
   assign fld.trap_imm = first_word[TRAP_LSB +: TRAP_W]; // RULE_15
   assign fld.branch_condition_field = first_word[COND_LSB +: COND_W]; // RULE_22
endmodule
`default_nettype wire

//--- rtl/eau_step.sv
/*
 Size-dependent step helper for write-back modes; outputs stay 32 bits wide.
 Assumes pure combinational use inside the core.
*/
`default_nettype none
module eau_step
   import eau_pkg::*;
(
   input wire eau_pkg::eau_size_e size,                // Operand size
   input wire logic [eau_pkg::REG_W-1:0] reg_val,      // Address register
   output logic [eau_pkg::REG_W-1:0] inc_val,          // Register plus step
   output logic [eau_pkg::REG_W-1:0] dec_val           // Register minus step
);
   logic [REG_W-1:0] step;
   // Step is one, two or four by access size
   always_comb
   begin
      unique case (size)
         EAU_SZ_BYTE: step = STEP_BYTE;
         EAU_SZ_WORD: step = STEP_WORD;
         default: step = STEP_LONG;
      endcase
   end
   assign inc_val = reg_val + step; // RULE_08
   assign dec_val = reg_val - step; // RULE_09
endmodule
`default_nettype wire

//--- rtl/eau_core.sv
/*
 Effective address unit: takes a decoded instruction, reads registers
 and extension words, and hands address, size and write-back to the
 memory bus stage in one registered cycle.
 Assumes the register file answers reads combinationally and that the
 bus stage accepts when out_ready is high. Pointer reads for the
 pointer-indirect mode are issued through the same output and the
 longword comes back on ptr_data.
*/
// What this block does
// RULE_01 - Instructions are handled as whole 16-bit words.
// RULE_02 - Operation field taken from the first word's top four bits.
// RULE_03 - Register selectors are 3 bits for address, 3 or 4 for data.
// RULE_04 - 24-bit extensions are 32-bit values with a zero top byte.
// RULE_05 - Register direct picks byte half, word half or full register.
// RULE_06 - Register indirect address is the register's low 24 bits.
// RULE_07 - Displacement added, 16-bit one sign-extended, low 24 bits used.
// RULE_08 - Post-increment uses old address, then adds 1, 2 or 4.
// RULE_09 - Pre-decrement subtracts 1, 2 or 4 first, writes back, uses result.
// RULE_10 - Short absolute address fills upper 16 bits with ones.
// RULE_11 - 16-bit absolute address is sign-extended from bit 15.
// RULE_12 - 24-bit absolute address used unchanged.
// RULE_13 - Immediate operand comes from an 8, 16 or 32-bit field.
// RULE_14 - Some bit operations carry a 3-bit bit number in the code.
// RULE_15 - Software trap carries 2-bit field choosing the vector address.
// RULE_16 - PC relative: sign-extended 8/16-bit displacement plus next PC.
// RULE_17 - Pointer indirect reads a longword, drops top byte as target.
// RULE_18 - Pointer address has zero upper bits, range 0 to ff.
// RULE_19 - ALU ops only register/immediate; moves exclude PC relative and pointer.
// RULE_20 - Bit ops use register, indirect or short absolute; bit number reg or imm.
// RULE_21 - Every produced memory address is 24 bits.
// RULE_22 - Branch condition field selects the tested flag condition.
// RULE_23 - Memory accesses take two states on a 16-bit path.
// RULE_24 - Address, size and write-back leave together in one cycle.
`default_nettype none
module eau_core
   import eau_pkg::*;
#(
   parameter int ADDR_WIDTH = 24 // Effective address width
)
(
   input wire logic clk,                                  // System clock
   input wire logic sys_rst,                              // Async reset, high
   input wire logic clk_en,                               // Freezes state when low
   input wire logic in_valid,                             // Decoded instruction offered
   output logic in_ready,                                 // Unit can take one
   input wire logic [eau_pkg::WORD_W-1:0] first_word,     // First instruction word
   input wire logic [eau_pkg::REG_W-1:0] ext_word,        // Extension, zero-filled above
   input wire eau_pkg::eau_mode_e mode,                   // Addressing mode
   input wire eau_pkg::eau_size_e size,                   // Operand size
   input wire eau_pkg::eau_class_e op_class,              // Instruction class
   input wire logic bit_num_from_reg,                     // Bit number given by register
   input wire logic is_trap,                              // Software trap instruction
   input wire logic [eau_pkg::ADDR_W-1:0] next_pc,        // Address after this instruction
   output logic [eau_pkg::SEL_W-1:0] reg_rd_sel,          // Register file read select
   input wire logic [eau_pkg::REG_W-1:0] reg_rd_data,     // Register file read data
   output logic [eau_pkg::SEL_W-1:0] bit_rd_sel,          // Bit-number register select
   input wire logic [eau_pkg::REG_W-1:0] bit_rd_data,     // Bit-number register data
   input wire logic [eau_pkg::REG_W-1:0] ptr_data,        // Longword read at pointer
   input wire logic ptr_valid,                            // Pointer data present
   output logic out_valid,                                // Result valid
   input wire logic out_ready,                            // Bus stage accepts
   output logic [eau_pkg::ADDR_W-1:0] ea_q,               // Effective address
   output logic ea_is_mem_q,                              // Address targets memory
   output eau_pkg::eau_size_e size_q,                     // Operand size out
   output logic [eau_pkg::REG_W-1:0] operand_q,           // Register or immediate operand
   output logic wb_en_q,                                  // Register write-back request
   output logic [eau_pkg::SEL_W-1:0] wb_sel_q,            // Write-back register
   output logic [eau_pkg::REG_W-1:0] wb_val_q,            // Write-back value
   output logic [eau_pkg::BITNUM_W-1:0] bit_num_q,        // Selected bit number
   output logic [eau_pkg::COND_W-1:0] cond_q,             // Branch condition select
   output logic [eau_pkg::ADDR_W-1:0] trap_vec_q,         // Trap vector address
   output logic is_target_q,                              // ea_q is a branch target
   output logic mode_err_q,                               // Mode illegal for class
   output logic [1:0] mem_states_q                        // Bus states for access
);
   typedef enum logic [1:0] {EAU_IDLE, EAU_PTR_WAIT, EAU_OUT} eau_state_e;

   eau_fld_if fld();
   eau_state_e state_q;
   logic [REG_W-1:0] inc_val;
   logic [REG_W-1:0] dec_val;
   logic [REG_W-1:0] ea_full;
   logic [REG_W-1:0] opnd;
   logic [ADDR_W-1:0] ptr_addr;
   logic legal;
   logic take;
   logic wb_en_d;
   logic [REG_W-1:0] wb_val_d;
   logic is_mem_d;

   // Field extraction from the first word
   eau_fields u_fields
   (
      .first_word(first_word), // RULE_01
      .fld(fld)
   );

   // Step helper for post-increment and pre-decrement
   eau_step u_step
   (
      .size(size),
      .reg_val(reg_rd_data),
      .inc_val(inc_val),
      .dec_val(dec_val)
   );

   // Sign extension used by displacement and absolute forms
   function automatic logic [REG_W-1:0] sext16(input logic [15:0] v);
      sext16 = {{16{v[15]}}, v};
   endfunction

   function automatic logic [REG_W-1:0] sext8(input logic [7:0] v);
      sext8 = {{24{v[7]}}, v};
   endfunction

   // Register direct operand slice by size and data selector
   function automatic logic [REG_W-1:0] reg_slice(input logic [REG_W-1:0] r, input eau_size_e s,
                                                   input logic upper);
      reg_slice = '0;
      unique case (s)
         EAU_SZ_BYTE: reg_slice = upper ? {24'h000000, r[7:0]} : {24'h000000, r[15:8]};
         EAU_SZ_WORD: reg_slice = upper ? {16'h0000, r[31:16]} : {16'h0000, r[15:0]};
         default: reg_slice = r;
      endcase
   endfunction

   // Mode legality per class
   function automatic logic mode_ok(input eau_class_e c, input eau_mode_e m);
      mode_ok = 1'b0;
      unique case (c)
         EAU_CL_ALU: mode_ok = (m == EAU_REG_DIRECT) || (m == EAU_IMM8) || (m == EAU_IMM16)
                               || (m == EAU_IMM32); // RULE_19
         EAU_CL_MOVE: mode_ok = !((m == EAU_PC_REL8) || (m == EAU_PC_REL16) || (m == EAU_PTR_IND)); // RULE_19
         EAU_CL_BIT: mode_ok = (m == EAU_REG_DIRECT) || (m == EAU_REG_IND) || (m == EAU_ABS8); // RULE_20
         EAU_CL_BRANCH: mode_ok = (m == EAU_PC_REL8) || (m == EAU_PC_REL16) || (m == EAU_PTR_IND)
                                  || (m == EAU_REG_IND) || (m == EAU_ABS24);
      endcase
   endfunction

   // Address register from second field, data register may use 4 bits
   assign reg_rd_sel = (mode == EAU_REG_DIRECT) ? fld.dsel_b[SEL_W-1:0] : fld.sel_a; // RULE_03
   assign bit_rd_sel = fld.sel_a;
   assign legal = mode_ok(op_class, mode);
   assign ptr_addr = {PTR_ZERO_FILL, ext_word[7:0]}; // RULE_18
   assign in_ready = (state_q == EAU_IDLE) && clk_en;
   assign take = in_valid && in_ready;
   assign out_valid = (state_q == EAU_OUT);

   // Full-width address before truncation to 24 bits
   always_comb
   begin
      ea_full = '0;
      opnd = '0;
      wb_en_d = 1'b0;
      wb_val_d = '0;
      is_mem_d = 1'b1;
      unique case (mode)
         EAU_REG_DIRECT:
         begin
            opnd = reg_slice(reg_rd_data, size, fld.dsel_b[SEL_W]); // RULE_05
            is_mem_d = 1'b0;
         end
         EAU_REG_IND: ea_full = reg_rd_data; // RULE_06
         EAU_REG_DISP16: ea_full = reg_rd_data + sext16(ext_word[15:0]); // RULE_07
         EAU_REG_DISP24: ea_full = reg_rd_data + {EXT_TOP_ZERO, ext_word[23:0]}; // RULE_04 RULE_07
         EAU_POST_INC:
         begin
            ea_full = reg_rd_data; // RULE_08
            wb_en_d = 1'b1;
            wb_val_d = inc_val;
         end
         EAU_PRE_DEC:
         begin
            ea_full = dec_val; // RULE_09
            wb_en_d = 1'b1;
            wb_val_d = dec_val;
         end
         EAU_ABS8: ea_full = {8'h00, SHORT_ABS_FILL, ext_word[7:0]}; // RULE_10
         EAU_ABS16: ea_full = sext16(ext_word[15:0]); // RULE_11
         EAU_ABS24: ea_full = {EXT_TOP_ZERO, ext_word[23:0]}; // RULE_12
         EAU_IMM8:
         begin
            opnd = {24'h000000, ext_word[7:0]}; // RULE_13
            is_mem_d = 1'b0;
         end
         EAU_IMM16:
         begin
            opnd = {16'h0000, ext_word[15:0]}; // RULE_13
            is_mem_d = 1'b0;
         end
         EAU_IMM32:
         begin
            opnd = ext_word; // RULE_13
            is_mem_d = 1'b0;
         end
         EAU_PC_REL8: ea_full = {8'h00, next_pc} + sext8(ext_word[7:0]); // RULE_16
         EAU_PC_REL16: ea_full = {8'h00, next_pc} + sext16(ext_word[15:0]); // RULE_16
         EAU_PTR_IND: ea_full = {8'h00, ptr_addr}; // RULE_18
      endcase
   end

   // Handshake sequencing; pointer mode waits for the longword
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         state_q <= EAU_IDLE;
      else if (clk_en)
      begin
         unique case (state_q)
            EAU_IDLE:
               if (take)
                  state_q <= (mode == EAU_PTR_IND && legal) ? EAU_PTR_WAIT : EAU_OUT;
            EAU_PTR_WAIT:
               if (ptr_valid)
                  state_q <= EAU_OUT;
            EAU_OUT:
               if (out_ready)
                  state_q <= EAU_IDLE;
            default: state_q <= EAU_IDLE;
         endcase
      end
   end

   // Result registers load together on take; in pointer mode ea_q and is_target_q load again when ptr_valid arrives
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         ea_q <= '0;
         ea_is_mem_q <= 1'b0;
         size_q <= EAU_SZ_BYTE;
         operand_q <= '0;
         wb_en_q <= 1'b0;
         wb_sel_q <= '0;
         wb_val_q <= '0;
         is_target_q <= 1'b0;
         mode_err_q <= 1'b0;
      end
      else if (clk_en && take)
      begin
         ea_q <= ea_full[ADDR_WIDTH-1:0]; // RULE_21 RULE_24
         ea_is_mem_q <= is_mem_d && legal && (mode != EAU_PTR_IND);
         size_q <= (mode == EAU_PTR_IND) ? EAU_SZ_LONG : size;
         operand_q <= opnd;
         wb_en_q <= wb_en_d && legal; // RULE_24
         wb_sel_q <= fld.sel_a;
         wb_val_q <= wb_val_d;
         is_target_q <= (op_class == EAU_CL_BRANCH) && (mode != EAU_PTR_IND);
         mode_err_q <= !legal;
      end
      else if (clk_en && state_q == EAU_PTR_WAIT && ptr_valid)
      begin
         // First byte of the pointer longword is discarded
         ea_q <= ptr_data[ADDR_W-1:0]; // RULE_17
         is_target_q <= 1'b1;
      end
   end

   // Side fields: bit number, condition, trap vector
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         bit_num_q <= '0;
         cond_q <= '0;
         trap_vec_q <= '0;
      end
      else if (clk_en && take)
      begin
         bit_num_q <= bit_num_from_reg ? bit_rd_data[BITNUM_W-1:0] : fld.bit_imm; // RULE_14 RULE_20
         cond_q <= fld.branch_condition_field; // RULE_22
         trap_vec_q <= is_trap ? TRAP_VEC_BASE + {20'h00000, fld.trap_imm, 2'b00} : '0; // RULE_15
      end
   end

   // Two-state on-chip memory access over the 16-bit path
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         mem_states_q <= '0;
      else if (clk_en && take)
         mem_states_q <= 2'(MEM_STATES); // RULE_23
   end
endmodule
`default_nettype wire

//--- sim/eau_core_chk.sv
/*
 Assertion checker for the effective address unit core ports.
 Assumes one clock domain with an active-high asynchronous reset.
*/
`default_nettype none
module eau_core_chk
   import eau_pkg::*;
(
   input wire logic clk, // System clock
   input wire logic sys_rst, // Reset, high
   input wire logic in_valid, // Offer
   input wire logic in_ready, // Unit idle
   input wire logic [eau_pkg::REG_W-1:0] ext_word, // Extension
   input wire eau_pkg::eau_mode_e mode, // Mode
   input wire eau_pkg::eau_class_e op_class, // Class
   input wire logic [eau_pkg::REG_W-1:0] reg_rd_data, // Register data
   input wire logic out_valid, // Result valid
   input wire logic out_ready, // Accept
   input wire logic [eau_pkg::ADDR_W-1:0] ea_q, // Address
   input wire logic ea_is_mem_q, // Memory target
   input wire eau_pkg::eau_size_e size_q, // Size out
   input wire logic wb_en_q, // Write-back
   input wire logic [eau_pkg::REG_W-1:0] wb_val_q, // Write-back value
   input wire logic mode_err_q, // Illegal mode
   input wire logic [1:0] mem_states_q // Bus states
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   // Step by size, kept apart from the design's own helper
   function automatic logic [31:0] stp(eau_size_e s);
      return (s == EAU_SZ_LONG) ? 32'h4 : (s == EAU_SZ_WORD) ? 32'h2 : 32'h1;
   endfunction

   // One instruction of a given mode and class taken
   sequence s_take(eau_mode_e m, eau_class_e c);
      in_valid && in_ready && mode == m && op_class == c;
   endsequence

   AST_BUSY: assert property (out_valid |-> !in_ready)
      else $error("Unit ready while holding a result");
   AST_ANSWER: assert property (in_valid && in_ready && mode != EAU_PTR_IND |=> out_valid)
      else $error("No result one cycle after take");
   AST_HOLD: assert property (out_valid && !out_ready |=> out_valid && $stable(ea_q) && $stable(wb_val_q))
      else $error("Result changed while stalled");
   AST_STATES: assert property (out_valid |-> mem_states_q == 2'h2)
      else $error("Access state count is not two");
   AST_POSTINC: assert property (s_take(EAU_POST_INC, EAU_CL_MOVE) |=> wb_en_q && ea_q == $past(reg_rd_data[23:0])
      && wb_val_q == $past(reg_rd_data) + stp(size_q))
      else $error("Post-increment address or write-back wrong");
   AST_PREDEC: assert property (s_take(EAU_PRE_DEC, EAU_CL_MOVE) |=> wb_en_q && ea_q == wb_val_q[23:0]
      && wb_val_q == $past(reg_rd_data) - stp(size_q))
      else $error("Pre-decrement address or write-back wrong");
   AST_ABS8: assert property (s_take(EAU_ABS8, EAU_CL_BIT) |=> ea_q == {16'hffff, $past(ext_word[7:0])})
      else $error("Short absolute address not filled with ones");
   AST_ILLEGAL: assert property (in_valid && in_ready && op_class == EAU_CL_ALU
      && mode inside {[EAU_REG_IND:EAU_ABS24]} |=> mode_err_q && !ea_is_mem_q && !wb_en_q)
      else $error("Memory mode accepted for arithmetic class");
endmodule

bind eau_core eau_core_chk eau_core_chk_i (.clk, .sys_rst, .in_valid, .in_ready, .ext_word, .mode, .op_class,
   .reg_rd_data, .out_valid, .out_ready, .ea_q, .ea_is_mem_q, .size_q, .wb_en_q, .wb_val_q, .mode_err_q, .mem_states_q);
`default_nettype wire

//--- sim/eau_part_model.sv
/*
 Register file and bus stage standing beside the address unit.
 Assumes the bench loads the registers and seeds randomness.
*/
`default_nettype none
module eau_part_model
   import eau_pkg::*;
(
   input wire logic clk, // System clock
   input wire logic sys_rst, // Reset, high
   input wire logic [eau_pkg::SEL_W-1:0] reg_rd_sel, // Operand select
   output logic [eau_pkg::REG_W-1:0] reg_rd_data, // Operand data
   input wire logic [eau_pkg::SEL_W-1:0] bit_rd_sel, // Bit select
   output logic [eau_pkg::REG_W-1:0] bit_rd_data, // Bit data
   input wire logic out_valid, // Result offered
   output logic out_ready, // Bus stage accepts
   input wire logic wb_en_q, // Write-back request
   input wire logic [eau_pkg::SEL_W-1:0] wb_sel_q, // Write-back register
   input wire logic [eau_pkg::REG_W-1:0] wb_val_q // Write-back value
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] regs [8];

   // Known contents, so an unknown read never slips through a compare
   initial foreach (regs[i]) regs[i] = $urandom;

   // Reads answer at once, as the core expects
   assign reg_rd_data = regs[reg_rd_sel];
   assign bit_rd_data = regs[bit_rd_sel];

   // Stalls now and then, so held results get exercised
   initial out_ready = 1'b0;
   always @(negedge clk) out_ready <= ($urandom % 3) != 0;

   // Write-back lands only when the result is accepted
   always @(posedge clk)
      if (!sys_rst && out_valid && out_ready && wb_en_q) regs[wb_sel_q] <= wb_val_q;
endmodule
`default_nettype wire

//--- sim/test_cpu_effective_address_unit.sv
/*
 Self-checking bench for the effective address unit core.
 Assumes the core, the partner model and the checker are compiled first.
*/
`default_nettype none
module test_cpu_effective_address_unit;
   import eau_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, sys_rst, clk_en, in_valid, in_ready, bit_num_from_reg, is_trap, ptr_valid, out_valid, out_ready;
   logic ea_is_mem_q, wb_en_q, is_target_q, mode_err_q;
   logic [15:0] first_word;
   logic [31:0] ext_word, reg_rd_data, bit_rd_data, ptr_data, operand_q, wb_val_q;
   logic [23:0] next_pc, ea_q, trap_vec_q;
   logic [2:0] reg_rd_sel, bit_rd_sel, wb_sel_q, bit_num_q;
   logic [3:0] cond_q;
   logic [1:0] mem_states_q;
   eau_mode_e mode;
   eau_size_e size, size_q;
   eau_class_e op_class;
   int failures, check_count;

   eau_core eau_core_i (.clk, .sys_rst, .clk_en, .in_valid, .in_ready, .first_word, .ext_word, .mode, .size, .op_class,
      .bit_num_from_reg, .is_trap, .next_pc, .reg_rd_sel, .reg_rd_data, .bit_rd_sel, .bit_rd_data, .ptr_data, .ptr_valid,
      .out_valid, .out_ready, .ea_q, .ea_is_mem_q, .size_q, .operand_q, .wb_en_q, .wb_sel_q, .wb_val_q, .bit_num_q,
      .cond_q, .trap_vec_q, .is_target_q, .mode_err_q, .mem_states_q);
   eau_part_model eau_part_model_i (.clk, .sys_rst, .reg_rd_sel, .reg_rd_data, .bit_rd_sel, .bit_rd_data,
      .out_valid, .out_ready, .wb_en_q, .wb_sel_q, .wb_val_q);

   // Counted comparison on four-state values
   task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e)
      begin
         failures++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic test_done;
      $display("Checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // Bounded wait on ready or valid at falling edges
   task automatic wait_sig(input logic rdy);
      int n;
      n = 0;
      while ((rdy ? in_ready : out_valid) !== 1'b1 && n < 40)
      begin
         @(negedge clk);
         n++;
      end
      if (n == 40)
      begin
         cmp("handshake", 32'h1, 32'h0);
         test_done();
      end
   endtask

   // One random instruction, expectation worked out beforehand
   task automatic run_instr;
      eau_mode_e m;
      eau_class_e c;
      eau_size_e sz;
      logic [15:0] fw;
      logic [31:0] ew, r, rb, op, st, wbv, pd;
      logic [23:0] e, pc;
      logic legal, imm, wb;
      // Previous write-back must land before registers are read
      wait_sig(1'b1);
      m = eau_mode_e'($urandom % 15);
      c = (m == EAU_PTR_IND) ? EAU_CL_BRANCH : eau_class_e'($urandom % 4);
      sz = eau_size_e'($urandom % 3);
      fw = 16'($urandom);
      pc = 24'($urandom);
      pd = $urandom;
      ew = $urandom;
      // Extension arrives zero-filled above its own width
      if (m inside {EAU_IMM8, EAU_ABS8, EAU_PC_REL8, EAU_PTR_IND}) ew[31:8] = '0;
      if (m inside {EAU_REG_DISP16, EAU_ABS16, EAU_IMM16, EAU_PC_REL16}) ew[31:16] = '0;
      if (m inside {EAU_REG_DISP24, EAU_ABS24}) ew[31:24] = '0;
      // Edge values make the 24-bit fold and the wrap show
      if ($urandom % 4 == 0) eau_part_model_i.regs[fw[6:4]] = ($urandom % 2) ? 32'h0 : 32'hffff_ffff;
      r = eau_part_model_i.regs[(m == EAU_REG_DIRECT) ? fw[2:0] : fw[6:4]];
      rb = eau_part_model_i.regs[fw[6:4]];
      op = (sz == EAU_SZ_LONG) ? r : (sz == EAU_SZ_WORD) ? (fw[3] ? {16'h0000, r[31:16]} : {16'h0000, r[15:0]})
         : (fw[3] ? {24'h000000, r[7:0]} : {24'h000000, r[15:8]});
      st = (sz == EAU_SZ_LONG) ? 32'h4 : (sz == EAU_SZ_WORD) ? 32'h2 : 32'h1;
      imm = m inside {EAU_IMM8, EAU_IMM16, EAU_IMM32};
      case (c)
         EAU_CL_ALU: legal = m == EAU_REG_DIRECT || imm;
         EAU_CL_MOVE: legal = !(m inside {EAU_PC_REL8, EAU_PC_REL16, EAU_PTR_IND});
         EAU_CL_BIT: legal = m inside {EAU_REG_DIRECT, EAU_REG_IND, EAU_ABS8};
         default: legal = m inside {EAU_PC_REL8, EAU_PC_REL16, EAU_PTR_IND, EAU_REG_IND, EAU_ABS24};
      endcase
      wb = legal && m inside {EAU_POST_INC, EAU_PRE_DEC};
      wbv = (m == EAU_PRE_DEC) ? r - st : r + st;
      case (m)
         EAU_REG_DISP16: e = 24'(r + {{16{ew[15]}}, ew[15:0]});
         EAU_REG_DISP24: e = 24'(r + ew);
         EAU_PRE_DEC: e = wbv[23:0];
         EAU_ABS8: e = {16'hffff, ew[7:0]};
         EAU_ABS16: e = {{8{ew[15]}}, ew[15:0]};
         EAU_ABS24: e = ew[23:0];
         EAU_PC_REL8: e = pc + {{16{ew[7]}}, ew[7:0]};
         EAU_PC_REL16: e = pc + {{8{ew[15]}}, ew[15:0]};
         EAU_PTR_IND: e = pd[23:0];
         default: e = r[23:0];
      endcase
      first_word = fw;
      ext_word = ew;
      mode = m;
      size = sz;
      op_class = c;
      next_pc = pc;
      bit_num_from_reg = 1'($urandom);
      is_trap = 1'($urandom);
      in_valid = 1'b1;
      wait_sig(1'b1);
      @(negedge clk);
      in_valid = 1'b0;
      // Pointer longword arrives after a random wait
      if (m == EAU_PTR_IND)
      begin
         repeat ($urandom % 3) @(negedge clk);
         cmp("out_valid", 32'h0, 32'(out_valid));
         cmp("ptr_addr", {24'h000000, ew[7:0]}, 32'(ea_q));
         ptr_data = pd;
         ptr_valid = 1'b1;
         @(negedge clk);
         ptr_valid = 1'b0;
         ptr_data = ~pd;
      end
      wait_sig(1'b0);
      cmp("mode_err", 32'(!legal), 32'(mode_err_q));
      cmp("wb_en", 32'(wb), 32'(wb_en_q));
      if (wb) cmp("wb_val", wbv, wb_val_q);
      if (wb) cmp("wb_sel", 32'(fw[6:4]), 32'(wb_sel_q));
      cmp("ea_is_mem", 32'(legal && !imm && !(m inside {EAU_REG_DIRECT, EAU_PTR_IND})), 32'(ea_is_mem_q));
      if (legal && !imm && m != EAU_REG_DIRECT) cmp("ea", 32'(e), 32'(ea_q));
      if (legal && (imm || m == EAU_REG_DIRECT)) cmp("operand", imm ? ew : op, operand_q);
      if (m == EAU_PTR_IND) cmp("target", 32'h1, 32'(is_target_q));
      else cmp("size", 32'(sz), 32'(size_q));
      if (legal && c == EAU_CL_BIT)
         cmp("bit_num", 32'(bit_num_from_reg ? rb[2:0] : fw[6:4]), 32'(bit_num_q));
      if (legal && c == EAU_CL_BRANCH) cmp("cond", 32'(fw[11:8]), 32'(cond_q));
      if (legal && is_trap) cmp("trap_vec", 32'h20 + 32'h4 * fw[5:4], 32'(trap_vec_q));
   endtask

   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // Hang guard well past the expected run length
   initial
   begin
      #5000000;
      cmp("run_end", 32'h1, 32'h0);
      test_done();
   end

   initial
   begin
      void'($urandom(47));
      {failures, check_count} = '0;
      {sys_rst, clk_en, in_valid, bit_num_from_reg, is_trap, ptr_valid} = 6'h30;
      {first_word, ext_word, ptr_data, next_pc} = '0;
      mode = EAU_REG_DIRECT;
      size = EAU_SZ_BYTE;
      op_class = EAU_CL_ALU;
      repeat (3) @(negedge clk);
      sys_rst = 1'b0;
      // A frozen unit must not take an offer
      clk_en = 1'b0;
      in_valid = 1'b1;
      repeat (3) @(negedge clk);
      cmp("in_ready", 32'h0, 32'(in_ready));
      cmp("out_valid", 32'h0, 32'(out_valid));
      in_valid = 1'b0;
      clk_en = 1'b1;
      repeat (400) run_instr();
      test_done();
   end
endmodule
`default_nettype wire
